/* File: design/audio_master_clock_and_trim.sv */
// Contract
// (R1) Processor clock from PLL, reference 5-35 MHz
// (R2) Two master clocks, crystal divided 1-4
// (R3) Divide-by-three only with 33.86 MHz reference
// (R4) Trim output is 16-bit pulse density stream
// (R5) Trim mode locks oscillator to audio rate
// (R6) Reset: divide-by-one, trim holds mid-scale
`timescale 1ns/100ps
module audio_master_clock_and_trim #(
	parameter int TRIM_PERIOD = amclk_pkg::TRIM_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Crystal reference sampled as a level
	input wire logic xtal_in,
	// Configuration from the control unit
	input wire amclk_pkg::clk_cfg_s cfg,
	// Audio receiver frame strobe and local sample strobe
	input wire logic rx_frame_tick,
	input wire logic local_frame_tick,
	// Outputs
	output logic audio_master_clock_out_a,
	output logic audio_master_clock_out_b,
	output logic trim_out,
	output logic [15:0] trim_value
);
	// ----------------------------------------
	// Divider helper
	// ----------------------------------------
	// Divide-by-three is refused unless the high-rate crystal is fitted
	function automatic logic [1:0] legal_div(input logic [1:0] d, input logic high_ref);
		if (d == amclk_pkg::DIV_BY_3 && !high_ref)
			legal_div = amclk_pkg::DIV_BY_1; // (R3)
		else
			legal_div = d;
	endfunction
	// Level for a crystal-edge count: high through the first half of the period
	// Only rising crystal edges are seen, so divide-by-three is high two edges of three
	function automatic logic div_high(input logic [1:0] cnt, input logic [1:0] d);
		div_high = (cnt <= {1'b0, d[1]});
	endfunction

	// ----------------------------------------
	// Crystal reference
	// ----------------------------------------
	// Processor clock itself comes from the analog PLL; only the reference passes here (R1)
	logic xtal_d_ff;
	logic xtal_rise;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			xtal_d_ff <= 1'b0;
		else
			xtal_d_ff <= xtal_in;
	end
	assign xtal_rise = xtal_in & ~xtal_d_ff;

	// ----------------------------------------
	// Master clock dividers
	// ----------------------------------------
	logic [1:0] div_a_ff;
	logic [1:0] div_b_ff;
	logic [1:0] cnt_a_ff;
	logic [1:0] cnt_b_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			div_a_ff <= amclk_pkg::DIV_RESET; // (R6)
			div_b_ff <= amclk_pkg::DIV_RESET; // (R6)
		end
		else
		begin
			div_a_ff <= legal_div(cfg.div_a, cfg.high_ref); // (R3)
			div_b_ff <= legal_div(cfg.div_b, cfg.high_ref); // (R3)
		end
	end

	// Divide-by-one follows the sampled crystal; others count rising edges (odd ratio not 50% duty)
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_a_ff <= 2'h0;
			audio_master_clock_out_a <= 1'b0;
		end
		else if (div_a_ff == amclk_pkg::DIV_BY_1)
		begin
			cnt_a_ff <= 2'h0;
			audio_master_clock_out_a <= xtal_in; // (R2)
		end
		else if (xtal_rise)
		begin
			if (cnt_a_ff >= div_a_ff)
			begin
				// Period of code+1 crystal edges closes: restart high
				cnt_a_ff <= 2'h0;
				audio_master_clock_out_a <= 1'b1; // (R2)
			end
			else
			begin
				cnt_a_ff <= cnt_a_ff + 2'h1;
				audio_master_clock_out_a <= div_high(cnt_a_ff + 2'h1, div_a_ff); // (R2)
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_b_ff <= 2'h0;
			audio_master_clock_out_b <= 1'b0;
		end
		else if (div_b_ff == amclk_pkg::DIV_BY_1)
		begin
			cnt_b_ff <= 2'h0;
			audio_master_clock_out_b <= xtal_in; // (R2)
		end
		else if (xtal_rise)
		begin
			if (cnt_b_ff >= div_b_ff)
			begin
				// Period of code+1 crystal edges closes: restart high
				cnt_b_ff <= 2'h0;
				audio_master_clock_out_b <= 1'b1; // (R2)
			end
			else
			begin
				cnt_b_ff <= cnt_b_ff + 2'h1;
				audio_master_clock_out_b <= div_high(cnt_b_ff + 2'h1, div_b_ff); // (R2)
			end
		end
	end

	// ----------------------------------------
	// Trim loop
	// ----------------------------------------
	// Frequency comparison over a fixed window; more received frames means local clock too slow
	logic [31:0] win_ff;
	logic signed [15:0] err_ff;
	logic win_end;
	assign win_end = (win_ff == 32'(TRIM_PERIOD - 1));
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			win_ff <= 32'h0;
		else if (!cfg.trim_en || win_end)
			win_ff <= 32'h0;
		else
			win_ff <= win_ff + 32'h1;
	end

	// ----------------------------------------
	// Frame tick comparison
	// ----------------------------------------
	// Coincident ticks cancel
	logic signed [1:0] tick_diff;
	always_comb
	begin
		if (rx_frame_tick && !local_frame_tick)
			tick_diff = 2'sh1;
		else if (local_frame_tick && !rx_frame_tick)
			tick_diff = -2'sh1;
		else
			tick_diff = 2'sh0;
	end

	// A tick on the closing cycle opens the next window instead of being lost
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			err_ff <= 16'sh0;
		else if (!cfg.trim_en)
			err_ff <= 16'sh0;
		else if (win_end)
			err_ff <= 16'(tick_diff); // (R5)
		else if (tick_diff > 2'sh0 && err_ff != 16'sh7FFF)
			err_ff <= err_ff + 16'sh1; // (R5)
		else if (tick_diff < 2'sh0 && err_ff != -16'sh8000)
			err_ff <= err_ff - 16'sh1; // (R5)
	end

	// Saturating step; slow but avoids loop overshoot
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			trim_value <= amclk_pkg::TRIM_MID; // (R6)
		else if (!cfg.trim_en)
			trim_value <= amclk_pkg::TRIM_MID; // (R6)
		else if (win_end && err_ff > 16'sh0 && trim_value != 16'hFFFF)
			trim_value <= trim_value + amclk_pkg::TRIM_STEP; // (R5)
		else if (win_end && err_ff < 16'sh0 && trim_value != 16'h0000)
			trim_value <= trim_value - amclk_pkg::TRIM_STEP; // (R5)
	end

	// ----------------------------------------
	// Trim stream
	// ----------------------------------------
	logic pdm_bit;
	pdm_modulator #(.WIDTH(amclk_pkg::TRIM_WIDTH)) u_pdm (
		.clk(clk),
		.nrst(nrst),
		.density(trim_value),
		.pdm_out(pdm_bit)
	);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			trim_out <= 1'b0;
		else
			trim_out <= pdm_bit; // (R4)
	end
endmodule // audio_master_clock_and_trim

/* File: common/amclk_pkg.sv */
package amclk_pkg;
	// ----------------------------------------
	// Divider selections
	// ----------------------------------------
	typedef enum logic [1:0] {DIV_BY_1 = 2'h0, DIV_BY_2 = 2'h1, DIV_BY_3 = 2'h2, DIV_BY_4 = 2'h3} mclk_div_e;
	localparam int TRIM_WIDTH = 16;
	localparam logic [15:0] TRIM_MID = 16'h8000;
	localparam logic [1:0] DIV_RESET = 2'h0;
	// ----------------------------------------
	// Reference limits and trim loop timing
	// ----------------------------------------
	localparam int REF_MIN_KHZ = 5000;
	localparam int REF_MAX_KHZ = 35000;
	localparam int CD_HIGH_RATE_KHZ = 33860;
	localparam int CLK_MHZ = 200;
	localparam int TRIM_PERIOD_US = 10;
	localparam int TRIM_PERIOD_CYC = TRIM_PERIOD_US * CLK_MHZ;
	localparam logic [15:0] TRIM_STEP = 16'h0001;
	typedef struct packed {
		logic [1:0] div_a;
		logic [1:0] div_b;
		logic trim_en;
		logic high_ref;
	} clk_cfg_s;
endpackage

/* File: design/pdm_modulator.sv */
`timescale 1ns/100ps
module pdm_modulator #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Density value and stream
	input wire logic [WIDTH-1:0] density,
	output logic pdm_out
);
	logic [WIDTH-1:0] acc_ff;
	logic [WIDTH:0] sum;
	assign sum = {1'b0, acc_ff} + {1'b0, density};
	// ----------------------------------------
	// First-order sigma-delta
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_ff <= '0;
			pdm_out <= 1'b0;
		end
		else
		begin
			acc_ff <= sum[WIDTH-1:0]; // (R4)
			pdm_out <= sum[WIDTH]; // (R4)
		end
	end
endmodule // pdm_modulator

/* File: dv/amclk_partner.sv */
`timescale 1ns/100ps
module amclk_partner (
	// Clock in, crystal side out
	input wire logic clk,
	output logic xtal_in,
	output logic local_frame_tick
);
	// --
	// Free-running 25 MHz crystal, no steering: loop checked open
	// --
	logic [6:0] cyc_ff = 7'h00;
	always @(posedge clk)
		cyc_ff <= cyc_ff + 7'h01;
	assign xtal_in = cyc_ff[2];
	assign local_frame_tick = cyc_ff == 7'h7F;
endmodule // amclk_partner

/* File: dv/amclk_asserts.sv */
`timescale 1ns/100ps
module amclk_asserts (
	// Watched ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic xtal_in,
	input wire amclk_pkg::clk_cfg_s cfg,
	input wire logic audio_master_clock_out_a,
	input wire logic audio_master_clock_out_b,
	input wire logic trim_out,
	input wire logic [15:0] trim_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence mid_held;
		(trim_value == 16'h8000)[*8];
	endsequence
	a_reset_state: assert property (disable iff (1'b0) !nrst ##1 !nrst |-> !trim_out && trim_value == 16'h8000)
		else $error("reset state");
	a_idle_mid: assert property ((!cfg.trim_en)[*2] |-> trim_value == 16'h8000)
		else $error("idle trim");
	a_clock_a_follows: assert property ((cfg.div_a == 2'h0 || cfg.div_a == 2'h2 && !cfg.high_ref)[*3]
		|-> audio_master_clock_out_a == $past(xtal_in)) else $error("clock a");
	a_clock_b_follows: assert property ((cfg.div_b == 2'h0 || cfg.div_b == 2'h2 && !cfg.high_ref)[*3]
		|-> audio_master_clock_out_b == $past(xtal_in)) else $error("clock b");
	a_trim_one_step: assert property (cfg.trim_en && $past(cfg.trim_en) && $changed(trim_value)
		|-> trim_value + 16'h0001 == $past(trim_value) || trim_value == $past(trim_value) + 16'h0001)
		else $error("trim step");
	a_pdm_mid_moves: assert property (mid_held |-> ##[1:4] $changed(trim_out))
		else $error("pdm stuck");
endmodule // amclk_asserts
bind audio_master_clock_and_trim amclk_asserts u_amclk_asserts (.*);

/* File: dv/audio_master_clock_and_trim_test.sv */
`timescale 1ns/100ps
module audio_master_clock_and_trim_test;
	typedef struct packed {logic [1:0] a; logic [1:0] b; logic hr; logic [7:0] ea; logic [7:0] eb;} row_s;
	// Toggles in 96 cycles at a crystal of 8 cycles
	row_s rows [4] = '{'{2'h0, 2'h1, 1'h0, 8'h18, 8'h0C}, '{2'h2, 2'h3, 1'h1, 8'h08, 8'h06},
		'{2'h3, 2'h2, 1'h0, 8'h06, 8'h18}, '{2'h1, 2'h0, 1'h1, 8'h0C, 8'h18}};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic xtal_in, local_frame_tick, out_a, out_b, trim_out, pa, pb;
	logic rx_frame_tick = 1'b0;
	logic rx_on = 1'b0;
	amclk_pkg::clk_cfg_s cfg = '0;
	logic [15:0] trim_value;
	logic [7:0] na, nb;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	amclk_partner u_amclk_partner (.clk(clk), .xtal_in(xtal_in), .local_frame_tick(local_frame_tick));
	audio_master_clock_and_trim #(.TRIM_PERIOD(20)) u_audio_master_clock_and_trim (.clk(clk), .nrst(nrst),
		.xtal_in(xtal_in), .cfg(cfg), .rx_frame_tick(rx_frame_tick), .local_frame_tick(local_frame_tick),
		.audio_master_clock_out_a(out_a), .audio_master_clock_out_b(out_b), .trim_out(trim_out),
		.trim_value(trim_value));
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #2.5 clk = !clk;
	// Receiver frames twice the local rate; hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rx_frame_tick <= rx_on && (cyc % 64 == 0);
		if (cyc == 10000)
		begin
			errors++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		check("reset trim", trim_value, 16'h8000);
		@(posedge clk);
		nrst <= 1'b1;
		// Mid-scale density gives one stream bit in two
		repeat (4) @(negedge clk);
		na = 8'h00;
		repeat (254)
		begin
			@(negedge clk);
			na += 8'(trim_out);
		end
		check("trim density", 16'(na), 16'h007F);
		foreach (rows[i])
		begin
			@(posedge clk);
			cfg <= '{rows[i].a, rows[i].b, 1'b0, rows[i].hr};
			repeat (32) @(negedge clk);
			pa = out_a;
			pb = out_b;
			na = 8'h00;
			nb = 8'h00;
			repeat (96)
			begin
				@(negedge clk);
				na += 8'(out_a ^ pa);
				nb += 8'(out_b ^ pb);
				pa = out_a;
				pb = out_b;
			end
			check("clock a toggles", 16'(na), 16'(rows[i].ea));
			check("clock b toggles", 16'(nb), 16'(rows[i].eb));
		end
		@(posedge clk);
		cfg.trim_en <= 1'b1;
		rx_on <= 1'b1;
		repeat (3000) @(negedge clk);
		check("trim raised", 16'(trim_value > 16'h8000), 16'h0001);
		@(posedge clk);
		cfg.trim_en <= 1'b0;
		repeat (2) @(negedge clk);
		check("trim idle", trim_value, 16'h8000);
		give_verdict();
	end
endmodule // audio_master_clock_and_trim_test
